// File: adc_corr_pkg.sv
// constants shared by the offset correction and gain control block
// assumes a 32-bit classic wishbone register bus and 11-bit two's complement samples
package adc_corr_pkg;
  localparam int SAMPLE_W = 11;
  localparam int ERR_W = SAMPLE_W + 1;
  localparam int ACC_W = 41;
  localparam int SHIFT_W = 5;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_W = 2 * SAMPLE_W;
  localparam int ADR_W = 8;
  // loop time constant: 2^(base + code) sampling clock cycles
  localparam int TC_BASE_SHIFT = 18;
  localparam logic [3:0] TC_CODE_MAX = 4'hb;
  // correction range in input terms, turned into output codes at 0 dB full scale
  localparam int OFFSET_LIMIT_MV = 10;
  localparam int FULL_SCALE_MV = 2000;
  localparam int CODES_PER_FS = 2048;
  localparam int OFFSET_LIMIT_LSB = OFFSET_LIMIT_MV * CODES_PER_FS / FULL_SCALE_MV;
  // gain in half-dB steps, 0 dB to 6 dB
  localparam logic [3:0] GAIN_MAX_STEP = 4'hc;
  localparam logic [3:0] GAIN_RESET = 4'h0;
  // register byte addresses
  localparam logic [ADR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADR_W-1:0] REG_EST_A = 8'h04;
  localparam logic [ADR_W-1:0] REG_EST_B = 8'h08;
  localparam logic [ADR_W-1:0] REG_STATUS = 8'h0c;
  // control field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_EXTREF_BIT = 1;
  localparam int CTRL_TC_LSB = 4;
  localparam int CTRL_GAIN_LSB = 8;
  // status field positions
  localparam int STAT_LEVEL_LSB = 0;
  localparam int STAT_EMPTY_BIT = 4;
  localparam int STAT_FULL_BIT = 5;
endpackage

// File: adc_offset_correction_gain_ctrl.sv
// offset correction loop, gain and reference selection, output fifo and register slave
// assumes samples arrive on clk_sys from the converter core and leave to output logic
`timescale 1ns/1ps

module corr_fifo #(
  parameter int WIDTH = 22,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys, // sampling clock
  input wire logic sys_rst, // synchronous reset
  input wire logic in_valid, // write request
  output logic in_ready, // space available
  input wire logic [WIDTH-1:0] in_data, // write data
  output logic out_valid, // data available
  input wire logic out_ready, // consumer takes word
  output logic [WIDTH-1:0] out_data, // oldest word
  output logic [$clog2(DEPTH):0] level // words held
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wr_reg;
  logic [PW-1:0] rd_reg;
  logic [PW:0] cnt_reg;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (cnt_reg != (PW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem_reg[rd_reg];
  assign level = cnt_reg;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) wr_reg <= wr_reg + 1'b1;
      if (pop) rd_reg <= rd_reg + 1'b1;
      cnt_reg <= cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule

module dc_loop
  import adc_corr_pkg::*;
(
  input wire logic clk_sys, // sampling clock
  input wire logic sys_rst, // synchronous reset
  input wire logic update, // accepted sample with estimation running
  input wire logic [SHIFT_W-1:0] shift, // log2 of time constant in cycles
  input wire logic signed [SAMPLE_W-1:0] sample, // raw sample
  output logic signed [SAMPLE_W-1:0] est, // current offset estimate
  output logic signed [SAMPLE_W-1:0] corrected // sample minus estimate
);
  localparam logic signed [ACC_W-1:0] LIM = ACC_W'(OFFSET_LIMIT_LSB);
  localparam logic signed [ERR_W-1:0] OUT_MAX = ERR_W'((1 << (SAMPLE_W-1)) - 1);
  localparam logic signed [ERR_W-1:0] OUT_MIN = -ERR_W'(1 << (SAMPLE_W-1));
  logic signed [ACC_W-1:0] acc_reg;
  logic signed [ACC_W-1:0] acc_next;
  logic signed [SAMPLE_W-1:0] est_reg;

  // first-order loop: est = acc / 2^shift, acc integrates the residual
  wire signed [ACC_W-1:0] est_raw = acc_reg >>> shift;
  wire at_hi = est_raw >= LIM;
  wire at_lo = est_raw <= -LIM;
  // the estimate has its own register and moves only on an update, so a new
  // time constant written while frozen cannot shift the held value
  wire signed [ACC_W-1:0] nxt_raw = acc_next >>> shift;
  wire signed [SAMPLE_W-1:0] est_next = (nxt_raw >= LIM) ? SAMPLE_W'(LIM) :
                                        (nxt_raw <= -LIM) ? -SAMPLE_W'(LIM) :
                                        nxt_raw[SAMPLE_W-1:0];
  assign est = est_reg;
  wire signed [ERR_W-1:0] err = ERR_W'(sample) - ERR_W'(est);
  // hold the integrator at the range edge so it cannot wind up past the limit
  wire clip = (at_hi && !err[ERR_W-1] && err != '0) || (at_lo && err[ERR_W-1]);
  assign acc_next = (update && !clip) ? acc_reg + ACC_W'(err) : acc_reg;
  // straight combinational subtraction: same timing enabled or not
  assign corrected = (err > OUT_MAX) ? OUT_MAX[SAMPLE_W-1:0] :
                     (err < OUT_MIN) ? OUT_MIN[SAMPLE_W-1:0] : err[SAMPLE_W-1:0];

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      acc_reg <= '0;
      est_reg <= '0;
    end else begin
      acc_reg <= acc_next;
      if (update) est_reg <= est_next;
    end
  end

  a_est_frozen: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !update |=> $stable(est))
    else $error("estimate moved without an update");
endmodule

module adc_offset_correction_gain_ctrl #(
  parameter int TC_BASE = adc_corr_pkg::TC_BASE_SHIFT // shorten for simulation
) (
  input wire logic clk_sys, // 25 MHz sampling clock
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write
  input wire logic [adc_corr_pkg::ADR_W-1:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  input wire logic samp_valid, // converter core sample valid
  output logic samp_ready, // block can take a sample
  input wire logic [adc_corr_pkg::SAMPLE_W-1:0] samp_a, // channel a raw
  input wire logic [adc_corr_pkg::SAMPLE_W-1:0] samp_b, // channel b raw
  output logic out_valid, // corrected pair available
  input wire logic out_ready, // output interface takes pair
  output logic [adc_corr_pkg::SAMPLE_W-1:0] out_a, // channel a corrected
  output logic [adc_corr_pkg::SAMPLE_W-1:0] out_b, // channel b corrected
  output logic [3:0] gain_step, // gain in half-dB steps to analog
  output logic ref_internal, // internal reference generation on
  output logic common_mode_pin_oe // drive common_mode_pin as output
);
  import adc_corr_pkg::*;

  logic en_reg;
  logic ext_ref_reg;
  logic [3:0] tc_reg;
  logic [3:0] gain_reg;
  logic ack_reg;
  logic [31:0] rdat_reg;
  logic [FIFO_W-1:0] fifo_out;
  logic [$clog2(FIFO_DEPTH):0] fifo_level;
  logic signed [SAMPLE_W-1:0] est_a;
  logic signed [SAMPLE_W-1:0] est_b;
  logic signed [SAMPLE_W-1:0] corr_a;
  logic signed [SAMPLE_W-1:0] corr_b;

  // register decode
  wire req = wb_cyc_i && wb_stb_i && !ack_reg;
  wire wr_ctrl = req && wb_we_i && (wb_adr_i == REG_CTRL);
  wire [31:0] ctrl_rd = {20'h0, gain_reg, tc_reg, 2'h0, ext_ref_reg, en_reg};
  wire [31:0] status_rd = {26'h0, !samp_ready, !out_valid, fifo_level};
  wire [31:0] rd_mux = (wb_adr_i == REG_CTRL) ? ctrl_rd :
                       (wb_adr_i == REG_EST_A) ? 32'(signed'(est_a)) :
                       (wb_adr_i == REG_EST_B) ? 32'(signed'(est_b)) :
                       (wb_adr_i == REG_STATUS) ? status_rd : 32'h0;
  wire [3:0] gain_wr = wb_dat_i[CTRL_GAIN_LSB +: 4];
  // values above 6 dB saturate rather than wrap
  wire [3:0] gain_next = (gain_wr > GAIN_MAX_STEP) ? GAIN_MAX_STEP : gain_wr;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      en_reg <= 1'b0;
      ext_ref_reg <= 1'b0;
      tc_reg <= 4'h0;
      gain_reg <= GAIN_RESET;
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0;
    end else begin
      ack_reg <= req;
      if (req) rdat_reg <= rd_mux;
      if (wr_ctrl && wb_sel_i[0]) begin
        en_reg <= wb_dat_i[CTRL_EN_BIT];
        ext_ref_reg <= wb_dat_i[CTRL_EXTREF_BIT];
        tc_reg <= wb_dat_i[CTRL_TC_LSB +: 4];
      end
      if (wr_ctrl && wb_sel_i[1]) gain_reg <= gain_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;
  assign gain_step = gain_reg;
  assign ref_internal = !ext_ref_reg;
  assign common_mode_pin_oe = !ext_ref_reg;

  // reserved codes are clamped to the longest constant so the loop stays bounded
  wire [3:0] tc_eff = (tc_reg > TC_CODE_MAX) ? TC_CODE_MAX : tc_reg;
  wire [SHIFT_W-1:0] loop_shift = SHIFT_W'(TC_BASE) + SHIFT_W'(tc_eff);
  wire take = samp_valid && samp_ready;
  wire loop_update = take && en_reg;

  dc_loop u_loop_a (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .update(loop_update),
    .shift(loop_shift),
    .sample(samp_a),
    .est(est_a),
    .corrected(corr_a)
  );

  dc_loop u_loop_b (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .update(loop_update),
    .shift(loop_shift),
    .sample(samp_b),
    .est(est_b),
    .corrected(corr_b)
  );

  corr_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .in_valid(samp_valid),
    .in_ready(samp_ready),
    .in_data({corr_b, corr_a}),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(fifo_out),
    .level(fifo_level)
  );

  assign out_a = fifo_out[SAMPLE_W-1:0];
  assign out_b = fifo_out[FIFO_W-1:SAMPLE_W];

  // checks
  // residual of each channel before saturation, for the subtraction checks
  wire signed [ERR_W-1:0] diff_a = ERR_W'(signed'(samp_a)) - ERR_W'(est_a);
  wire signed [ERR_W-1:0] diff_b = ERR_W'(signed'(samp_b)) - ERR_W'(est_b);
  wire [SAMPLE_W-1:0] sat_hi = {1'b0, {(SAMPLE_W-1){1'b1}}};
  wire [SAMPLE_W-1:0] sat_lo = {1'b1, {(SAMPLE_W-1){1'b0}}};

  // stream
  a_subtract_exact: assert property (@(posedge clk_sys) disable iff (sys_rst)
    take |-> ERR_W'(corr_a) == diff_a
      || (diff_a > ERR_W'(corr_a) && corr_a == sat_hi)
      || (diff_a < ERR_W'(corr_a) && corr_a == sat_lo))
    else $error("channel a output is not sample minus estimate");
  a_subtract_b: assert property (@(posedge clk_sys) disable iff (sys_rst)
    take |-> ERR_W'(corr_b) == diff_b
      || (diff_b > ERR_W'(corr_b) && corr_b == sat_hi)
      || (diff_b < ERR_W'(corr_b) && corr_b == sat_lo))
    else $error("channel b output is not sample minus estimate");
  a_no_delay: assert property (@(posedge clk_sys) disable iff (sys_rst)
    take && !out_valid |=> out_valid && out_a == $past(corr_a) && out_b == $past(corr_b))
    else $error("corrected sample delayed beyond one register");
  a_out_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    out_valid && !out_ready |=> out_valid && $stable(out_a) && $stable(out_b))
    else $error("corrected pair changed before it was taken");
  a_stall_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    samp_valid && !samp_ready |=> $stable(est_a) && $stable(est_b))
    else $error("refused sample moved the estimate");
  a_chan_idle: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !take |=> $stable(est_a) && $stable(est_b))
    else $error("estimate moved without a sample");

  // loop
  a_est_limit: assert property (@(posedge clk_sys) disable iff (sys_rst)
    est_a <= SAMPLE_W'(OFFSET_LIMIT_LSB) && est_a >= -SAMPLE_W'(OFFSET_LIMIT_LSB)
      && est_b <= SAMPLE_W'(OFFSET_LIMIT_LSB) && est_b >= -SAMPLE_W'(OFFSET_LIMIT_LSB))
    else $error("offset estimate beyond correction range");
  a_frozen_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !en_reg ##1 !en_reg |-> $stable(est_a) && $stable(est_b))
    else $error("estimate moved while frozen");
  a_tc_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !en_reg && !$past(en_reg) && $changed(tc_reg) |-> $stable(est_a) && $stable(est_b))
    else $error("time constant change moved the frozen estimate");
  a_tc_select: assert property (@(posedge clk_sys) disable iff (sys_rst)
    tc_reg <= TC_CODE_MAX |-> loop_shift == SHIFT_W'(TC_BASE) + SHIFT_W'(tc_reg))
    else $error("time constant shift does not follow code");

  // configuration and reset
  a_reset_state: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $fell(sys_rst) |-> !en_reg && est_a == '0 && est_b == '0 && gain_reg == GAIN_RESET)
    else $error("defaults wrong after reset");
  a_reset_idle: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $fell(sys_rst) |-> !out_valid && samp_ready && ref_internal && common_mode_pin_oe
      && !wb_ack_o)
    else $error("outputs not idle after reset");
  a_gain_range: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wr_ctrl && wb_sel_i[1] |=> gain_reg <= GAIN_MAX_STEP && gain_step == gain_reg)
    else $error("gain outside 0 to 6 dB");
  a_gain_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wr_ctrl && wb_sel_i[1] |=> gain_step == (($past(gain_wr) > GAIN_MAX_STEP) ?
      GAIN_MAX_STEP : $past(gain_wr)))
    else $error("gain does not follow the written step");
  a_gain_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !(wr_ctrl && wb_sel_i[1]) |=> $stable(gain_step))
    else $error("gain moved without a write");
  a_ref_pin: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(ext_ref_reg) |-> !common_mode_pin_oe && !ref_internal)
    else $error("common mode pin still driven in external mode");
endmodule

// File: adc_core_model.sv
// far-side model: converter core feeding sample pairs and an output consumer that can stall
// assumes the bench sets go, stall and the sample values just after a rising edge
`timescale 1ns/1ps

module adc_core_model
  import adc_corr_pkg::*;
(
  input wire logic go, // offer a sample pair every cycle
  input wire logic stall, // consumer refuses words
  input wire logic [SAMPLE_W-1:0] val_a, // channel a value to send
  input wire logic [SAMPLE_W-1:0] val_b, // channel b value to send
  output logic samp_valid, // pair offered
  output logic [SAMPLE_W-1:0] samp_a, // channel a raw
  output logic [SAMPLE_W-1:0] samp_b, // channel b raw
  output logic out_ready // consumer takes pair
);
  // idle lines carry the inverse value so stale data never looks valid
  assign samp_valid = go;
  assign samp_a = go ? val_a : ~val_a;
  assign samp_b = go ? val_b : ~val_b;
  assign out_ready = !stall;
endmodule

// File: adc_offset_correction_gain_ctrl_tb.sv
// self-checking bench: wishbone register tasks plus a streaming core model
// assumes TC_BASE shortened to 2 so the loop settles within a few hundred cycles
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin error_cnt++; \
  $display("BAD t=%0t got %h exp %h", $time, (a), (e)); end end

module adc_offset_correction_gain_ctrl_tb;
  import adc_corr_pkg::*;
  logic clk_sys = 0, sys_rst = 1, cyc = 0, stb = 0, we = 0, go = 0, stall = 0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, q;
  logic [SAMPLE_W-1:0] val_a = 11'h019, val_b = 11'h7fd, sa, sb, oa, ob;
  logic [31:0] dat_o;
  logic ack, sv, sr, ov, ordy, ref_int, cm_oe;
  logic [3:0] gain;
  int error_cnt = 0, comparisons = 0, cyc_cnt = 0;

  always #20 clk_sys = ~clk_sys;

  adc_core_model adc_core_model_inst (.go(go), .stall(stall), .val_a(val_a), .val_b(val_b),
    .samp_valid(sv), .samp_a(sa), .samp_b(sb), .out_ready(ordy));

  adc_offset_correction_gain_ctrl #(.TC_BASE(2)) adc_offset_correction_gain_ctrl_inst (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .samp_valid(sv), .samp_ready(sr), .samp_a(sa), .samp_b(sb), .out_valid(ov),
    .out_ready(ordy), .out_a(oa), .out_b(ob), .gain_step(gain), .ref_internal(ref_int),
    .common_mode_pin_oe(cm_oe));

  task give_verdict;
    $display("checks %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // classic cycle: hold everything until ack is seen at an edge
  task wbs(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_sys);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    do @(posedge clk_sys); while (ack !== 1'b1);
    q = dat_o;
    cyc <= 0;
    stb <= 0;
  endtask

  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    wbs(w, a, d, 4'hf);
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    wb(0, a, 32'h0);
    `CHK(q, e)
  endtask

  task wait_out;
    repeat (300) @(posedge clk_sys);
    #1;
  endtask

  always @(posedge clk_sys) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end

  initial begin
    repeat (3) @(posedge clk_sys);
    sys_rst <= 0;
    rd_chk(REG_CTRL, 32'h0);
    `CHK({gain, ref_int, cm_oe}, 6'h03)
    $display("reset defaults done");
    go <= 1;
    wait_out();
    `CHK({oa, ob}, {11'h019, 11'h7fd})
    wb(1, REG_CTRL, 32'h1);
    wait_out();
    rd_chk(REG_EST_A, 32'h0000000a);
    rd_chk(REG_EST_B, 32'hfffffffd);
    `CHK({oa, ob}, {11'h00f, 11'h000})
    $display("loop running done");
    wb(1, REG_CTRL, 32'h0);
    val_a <= 11'h064;
    val_b <= 11'h007;
    wait_out();
    rd_chk(REG_EST_A, 32'h0000000a);
    `CHK({oa, ob}, {11'h05a, 11'h00a})
    $display("freeze done");
    for (int c = 0; c <= 11; c++) begin
      wb(1, REG_CTRL, 32'(c) << CTRL_TC_LSB);
      rd_chk(REG_CTRL, 32'(c) << CTRL_TC_LSB);
    end
    rd_chk(REG_EST_A, 32'h0000000a);
    wb(1, REG_CTRL, 32'h100);
    `CHK(gain, 4'h1)
    wb(1, REG_CTRL, 32'hc00);
    `CHK(gain, GAIN_MAX_STEP)
    wb(1, REG_CTRL, 32'hf02);
    rd_chk(REG_CTRL, 32'hc02);
    `CHK({gain, ref_int, cm_oe}, 6'h30)
    wbs(1, REG_CTRL, 32'h301, 4'h2);
    rd_chk(REG_CTRL, 32'h302);
    rd_chk(8'h10, 32'h0);
    $display("config done");
    go <= 0;
    repeat (5) @(posedge clk_sys);
    stall <= 1;
    go <= 1;
    @(posedge clk_sys);
    @(posedge clk_sys);
    #1;
    `CHK(ov, 1'b1)
    repeat (12) @(posedge clk_sys);
    #1;
    `CHK(sr, 1'b0)
    rd_chk(REG_STATUS, 32'h28);
    go <= 0;
    stall <= 0;
    repeat (12) @(posedge clk_sys);
    rd_chk(REG_STATUS, 32'h10);
    $display("fifo done");
    give_verdict();
  end
endmodule
